// ### verif/uart_port_with_flow_control_bench.sv
`timescale 1ns/10ps
module uart_port_with_flow_control_bench;
  import uart_pkg::*;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic TXD, RXD, CTS_N, RTS_N, RXD_TIMER, IRQ;
  logic TX_DMA_REQ, RX_DMA_REQ, DMA_PRIO_HIGH;
  logic TX_DMA_ACK = 1'b0;
  logic RX_DMA_ACK = 1'b0;
  logic [7:0] TX_DMA_DATA = 8'h00;
  logic [7:0] RX_DMA_DATA;
  logic [31:0] q;
  logic e;
  logic [4:0] fmts [4] = '{5'h00, 5'h19, 5'h0a, 5'h1f};
  logic [7:0] dls [4] = '{8'h01, 8'h02, 8'h01, 8'h02};
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  uart_port #(.HAS_FLOW(1'b1)) u_uart_port (
    .CLK(CLK), .RSTN(RSTN), .APB_REQ(req), .APB_RSP(rsp),
    .TXD(TXD), .RXD(RXD), .CTS_N(CTS_N), .RTS_N(RTS_N),
    .RXD_TIMER(RXD_TIMER), .TX_DMA_REQ(TX_DMA_REQ),
    .TX_DMA_ACK(TX_DMA_ACK), .TX_DMA_DATA(TX_DMA_DATA),
    .RX_DMA_REQ(RX_DMA_REQ), .RX_DMA_ACK(RX_DMA_ACK),
    .RX_DMA_DATA(RX_DMA_DATA), .DMA_PRIO_HIGH(DMA_PRIO_HIGH), .IRQ(IRQ)
  );

  uart_remote u_uart_remote (
    .clk(CLK), .txd_in(TXD), .rxd_out(RXD), .cts_n(CTS_N)
  );

  always #50 CLK = ~CLK;

  // run should need well under a third of this
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic chk_word(input logic [31:0] g, x, input string w);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, x);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, x, input string w);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %0t %s got %b exp %b", $time, w, g, x);
    end
  endtask : chk_bit

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge CLK);
    req.penable <= 1'b1;
    do @(posedge CLK); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string w);
    apb(1'b0, a, 32'h0);
    chk_word(q, x, w);
  endtask : rd

  task automatic wait_got();
    int k;
    k = 0;
    while (u_uart_remote.got.size() == 0 && k < 3000) begin
      @(posedge CLK);
      k++;
    end
    chk_word(32'(u_uart_remote.got.size()), 32'h1, "frame seen");
  endtask : wait_got

  initial begin
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(ADDR_FMT, 32'(FMT_RST), "fmt reset");
    chk_bit(RXD_TIMER, 1'b1, "timer line idle");
    rd(ADDR_DLL, 32'(DLL_RST), "dll reset");
    rd(ADDR_DLH, 32'(DLH_RST), "dlh reset");
    rd(ADDR_RTSL, 32'(RTSL_RST), "rtsl reset");
    chk_bit(DMA_PRIO_HIGH, 1'b0, "prio reset");
    apb(1'b0, 8'h3c, 32'h0);
    chk_bit(e, 1'b1, "unmapped err");
    chk_word(q, 32'h0, "unmapped data");
    wr(ADDR_DLH, 32'h5a);
    rd(ADDR_DLH, 32'h5a, "dlh rw");
    wr(ADDR_DLH, 32'h0);
    $display("test registers done");
    // formats span 7 to 12 bit frames, rate follows divisor
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_FMT, 32'(fmts[i]));
      wr(ADDR_DLL, 32'(dls[i]));
      u_uart_remote.nb = int'(fmts[i][1:0]) + 5;
      u_uart_remote.pe = fmts[i][F_PAR];
      u_uart_remote.ev = fmts[i][F_EVEN];
      u_uart_remote.bit_clks = int'(dls[i]) * 16;
      wr(ADDR_TXD, 32'h96 + i);
      wait_got();
      chk_word(32'(u_uart_remote.got.pop_front()),
               (32'h96 + i) & ((32'h1 << u_uart_remote.nb) - 1),
               "tx data");
      repeat (80) @(posedge CLK);
    end
    chk_word(32'(u_uart_remote.par_bad), 32'h0, "parity");
    chk_word(32'(u_uart_remote.stop_bad), 32'h0, "stop");
    wr(ADDR_FMT, 32'(FMT_RST));
    wr(ADDR_DLL, 32'h1);
    u_uart_remote.nb = 8;
    u_uart_remote.pe = 1'b0;
    u_uart_remote.bit_clks = 16;
    $display("test tx formats done");
    u_uart_remote.cts_n <= 1'b1;
    wr(ADDR_TXD, 32'h3c);
    repeat (300) @(posedge CLK);
    chk_bit(TXD, 1'b1, "cts hold");
    u_uart_remote.cts_n <= 1'b0;
    wait_got();
    chk_word(32'(u_uart_remote.got.pop_front()), 32'h3c,
             "cts data");
    repeat (20) @(posedge CLK);
    $display("test flow hold done");
    // bypass: one tick per bit, interrupt only at shift end
    wr(ADDR_DLL, 32'h10);
    wr(ADDR_CTRL, 32'h11);
    wr(ADDR_ICLR, 32'h1f);
    wr(ADDR_TXD, 32'ha5);
    repeat (30) @(posedge CLK);
    rd(ADDR_STAT, 32'h0, "no tx irq at load");
    wait_got();
    chk_word(32'(u_uart_remote.got.pop_front()), 32'ha5,
             "bypass data");
    repeat (20) @(posedge CLK);
    rd(ADDR_STAT, 32'h1, "tx irq at shift end");
    // infrared: a zero bit is a three tick low pulse
    wr(ADDR_DLL, 32'h1);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_TXD, 32'h0);
    wait (TXD == 1'b0);
    @(posedge CLK);
    chk_bit(TXD, 1'b0, "sir pulse low");
    repeat (4) @(posedge CLK);
    chk_bit(TXD, 1'b1, "sir pulse end");
    repeat (200) @(posedge CLK);
    u_uart_remote.got.delete();
    wr(ADDR_CTRL, 32'h0);
    $display("test bypass and infrared done");
    // fifo of four, fifth byte overruns
    wr(ADDR_ICLR, 32'h1f);
    wr(ADDR_IEN, 32'h2);
    wr(ADDR_RTSL, 32'h1);
    wr(ADDR_CTRL, 32'h4);
    chk_bit(IRQ, 1'b0, "irq idle");
    for (int i = 0; i < 5; i++) begin
      u_uart_remote.send(8'h40 + 8'(i));
      repeat (4) @(posedge CLK);
      chk_bit(RTS_N, i >= 1, "rts level");
    end
    chk_bit(IRQ, 1'b1, "irq rx");
    rd(ADDR_STAT, 32'h12, "stat rx ovr");
    for (int i = 0; i < 4; i++)
      rd(ADDR_RXD, 32'h40 + i, "rx data");
    chk_bit(RTS_N, 1'b0, "rts drained");
    wr(ADDR_IEN, 32'h0);
    repeat (2) @(posedge CLK);
    chk_bit(IRQ, 1'b0, "irq masked");
    wr(ADDR_IEN, 32'h2);
    wr(ADDR_ICLR, 32'h12);
    repeat (2) @(posedge CLK);
    chk_bit(IRQ, 1'b0, "irq cleared");
    rd(ADDR_STAT, 32'h0, "stat clear");
    $display("test rx fifo done");
    wr(ADDR_CTRL, 32'h28);
    repeat (2) @(posedge CLK);
    chk_bit(DMA_PRIO_HIGH, 1'b1, "prio set");
    chk_bit(TX_DMA_REQ, 1'b1, "tx dma req");
    TX_DMA_DATA <= 8'h5a;
    TX_DMA_ACK <= 1'b1;
    @(posedge CLK);
    TX_DMA_ACK <= 1'b0;
    wait_got();
    chk_word(32'(u_uart_remote.got.pop_front()), 32'h5a, "tx dma");
    u_uart_remote.send(8'h77);
    repeat (4) @(posedge CLK);
    chk_bit(RX_DMA_REQ, 1'b1, "rx dma req");
    chk_word(32'(RX_DMA_DATA), 32'h77, "rx dma data");
    RX_DMA_ACK <= 1'b1;
    @(posedge CLK);
    RX_DMA_ACK <= 1'b0;
    repeat (2) @(posedge CLK);
    chk_bit(RX_DMA_REQ, 1'b0, "rx dma done");
    $display("test dma done");
    tally_and_finish();
  end
endmodule : uart_port_with_flow_control_bench

// ### verif/uart_remote.sv
`timescale 1ns/10ps
module uart_remote (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd_in,
  output logic rxd_out,
  output logic cts_n
);
  int bit_clks = 16;
  int nb = 8;
  bit pe = 1'b0;
  bit ev = 1'b0;
  int par_bad = 0;
  int stop_bad = 0;
  logic [7:0] got [$];

  initial begin
    rxd_out = 1'b1;
    cts_n = 1'b0;
  end

  task automatic send(input logic [7:0] d);
    rxd_out <= 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd_out <= d[i];
      repeat (bit_clks) @(posedge clk);
    end
    if (pe) begin
      rxd_out <= ev ? ^d : ~^d;
      repeat (bit_clks) @(posedge clk);
    end
    rxd_out <= 1'b1;
    repeat (bit_clks) @(posedge clk);
  endtask : send

  always begin : rx_mon
    logic [7:0] d;
    @(negedge txd_in);
    repeat (bit_clks / 2) @(posedge clk);
    d = 8'h00;
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge clk);
      d[i] = txd_in;
    end
    if (pe) begin
      repeat (bit_clks) @(posedge clk);
      if (txd_in !== (ev ? ^d : ~^d)) par_bad++;
    end
    repeat (bit_clks) @(posedge clk);
    if (txd_in !== 1'b1) stop_bad++;
    got.push_back(d);
  end
endmodule : uart_remote

// ### verilog/uart_baud.sv
`timescale 1ns/10ps
module uart_baud
  import uart_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // divisor in, sample tick out
  input wire logic [15:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } baud_state_t;

  baud_state_t s_reg;
  baud_state_t s_next;
  logic [15:0] last;

  // a zero divisor wraps to the full 65536 count
  // zero gives slowest rate
  assign last = divisor - 16'h0001;
  assign tick = s_reg.tick;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    // a smaller divisor written mid-count must not wait a full wrap
    if (s_reg.cnt >= last) begin
      s_next.cnt = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // one tick per divisor count
  a_tick_space: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && divisor > 16'h0001) |=> !tick)
    else $error("sample ticks closer than the divisor");
endmodule : uart_baud

// ### verilog/uart_pkg.sv
package uart_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FMT = 8'h04;
  localparam logic [7:0] ADDR_DLL = 8'h08;
  localparam logic [7:0] ADDR_DLH = 8'h0c;
  localparam logic [7:0] ADDR_TXD = 8'h10;
  localparam logic [7:0] ADDR_RXD = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_IEN = 8'h1c;
  localparam logic [7:0] ADDR_ICLR = 8'h20;
  localparam logic [7:0] ADDR_LINE = 8'h24;
  localparam logic [7:0] ADDR_RTSL = 8'h28;
  // port_global_control fields
  localparam int CTRL_W = 6;
  localparam int C_BYPASS = 0;
  localparam int C_SIR = 1;
  localparam int C_AFLOW = 2;
  localparam int C_DMA = 3;
  localparam int C_TXSEL = 4;
  localparam int C_PRIO = 5;
  // format fields: [1:0] data bits-5, [2] two stops, [3] parity, [4] even
  localparam int FMT_W = 5;
  localparam int F_STOP2 = 2;
  localparam int F_PAR = 3;
  localparam int F_EVEN = 4;
  // status bits
  localparam int ST_W = 5;
  localparam int S_TX = 0;
  localparam int S_RX = 1;
  localparam int S_PE = 2;
  localparam int S_FE = 3;
  localparam int S_OE = 4;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [FMT_W-1:0] FMT_RST = 5'h03;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLH_RST = 8'h00;
  localparam logic [2:0] RTSL_RST = 3'h3;
  // oversampling counts, frame length limits and fifo depth
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] SIR_PULSE = 4'h3;
  localparam logic [3:0] FRAME_MIN = 4'h7;
  localparam logic [3:0] FRAME_MAX = 4'hc;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BITS = 2'b01
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
endpackage : uart_pkg

// ### verilog/uart_port.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - five to eight data bits, parity, stops
// - frame spans seven to twelve bits
// - holding stage plus shifter for transmit, shifter plus four-byte fifo for receive
// - separate transmit and receive dma requests
// - dma requests low priority by default
// - bit clock is clock over divisor, sixteen unless bypassed
// - divisor built from high and low bytes
// - rate from clock/1048576 up to clock
// - tx and rx interrupts individually masked
// - selectable transmit interrupt timing in dma
// - high clear-to-send stops new characters
// - raise request-to-send above high-water level
// - flow pins only on flow instances
// - optional serial infrared pulse mode
// - receive line offered to timer
module uart_port
  import uart_pkg::*;
#(
  parameter bit HAS_FLOW = 1'b1
)(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register bus
  input wire apb_req_t APB_REQ,
  output apb_rsp_t APB_RSP,
  // serial line
  output logic TXD,
  input wire logic RXD,
  input wire logic CTS_N,
  output logic RTS_N,
  output logic RXD_TIMER,
  // dma channels
  output logic TX_DMA_REQ,
  input wire logic TX_DMA_ACK,
  input wire logic [7:0] TX_DMA_DATA,
  output logic RX_DMA_REQ,
  input wire logic RX_DMA_ACK,
  output logic [7:0] RX_DMA_DATA,
  output logic DMA_PRIO_HIGH,
  // interrupt
  output logic IRQ
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [FMT_W-1:0] fmt;
    logic [7:0] dll;
    logic [7:0] dlh;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] ien;
    logic [2:0] rtsl;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] thr;
    logic thr_v;
    logic [11:0] tsh;
    logic [3:0] tbits;
    logic [3:0] tsub;
    logic tx_out;
    rx_state_t rst;
    logic [3:0] rsub;
    logic [3:0] rbits;
    logic [10:0] rsh;
    logic rlow;
    logic [3:0][7:0] fifo;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic rts_n;
    logic rxd_d;
  } port_state_t;

  port_state_t s_reg;
  port_state_t s_next;
  logic [1:0] rst_sync;
  logic rst_n;
  logic tick;
  logic bypass;
  logic sir;
  logic cts_ok;
  logic [3:0] flen;
  logic [3:0] wl;
  logic tbit_end;
  logic rsample;
  logic rbit;
  logic wr;
  logic rd;
  logic push;
  logic pop;
  logic tx_load;

  function automatic logic [7:0] low_bits(input logic [7:0] d,
                                          input logic [3:0] n);
    low_bits = d & 8'(~(9'h1ff << n));
  endfunction : low_bits

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // divisor of 0 counts 65536, giving clock/1048576 at the slow end
  // divisor halves joined
  uart_baud u_baud (
    .clk(CLK),
    .rst_n(rst_n),
    .divisor({s_reg.dlh, s_reg.dll}),
    .tick(tick)
  );

  assign bypass = s_reg.ctrl[C_BYPASS];
  assign sir = s_reg.ctrl[C_SIR];
  assign wl = 4'h5 + {2'b00, s_reg.fmt[1:0]};
  assign flen = 4'h1 + wl + {3'b000, s_reg.fmt[F_PAR]}
                + (s_reg.fmt[F_STOP2] ? 4'h2 : 4'h1);
  assign cts_ok = !HAS_FLOW || !CTS_N;
  // sixteen ticks per bit unless bypassed
  assign tbit_end = tick && (bypass || s_reg.tsub == OVS_LAST);
  // centre sample; infrared waits to the bit end
  assign rsample = tick && (bypass || s_reg.rsub ==
                   (sir ? OVS_LAST : OVS_MID));
  // any low pulse inside a bit is a zero
  assign rbit = sir ? !(s_reg.rlow || !s_reg.rxd_d) : s_reg.rxd_d;
  assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
  assign pop = s_reg.cnt != 3'h0 && ((s_reg.ctrl[C_DMA] && RX_DMA_ACK)
               || (!s_reg.ctrl[C_DMA] && rd
                   && APB_REQ.paddr == ADDR_RXD));
  // no new character while clear-to-send is high
  // bypass loads on a tick so the start bit is a whole bit long
  assign tx_load = s_reg.thr_v && s_reg.tbits == 4'h0 && cts_ok
                   && (!bypass || tick);

  always_comb begin
    logic [10:0] al;
    logic [7:0] d;
    al = '0;
    d = '0;
    push = 1'b0;
    s_next = s_reg;
    s_next.rxd_d = RXD;
    // register bus
    if (APB_REQ.psel && !APB_REQ.penable) begin
      s_next.pslverr = 1'b0;
      case (APB_REQ.paddr)
        ADDR_CTRL: s_next.prdata = 32'(s_reg.ctrl);
        ADDR_FMT: s_next.prdata = 32'(s_reg.fmt);
        ADDR_DLL: s_next.prdata = 32'(s_reg.dll);
        ADDR_DLH: s_next.prdata = 32'(s_reg.dlh);
        ADDR_RXD: s_next.prdata = 32'(s_reg.fifo[s_reg.rp]);
        ADDR_STAT: s_next.prdata = 32'(s_reg.stat);
        ADDR_IEN: s_next.prdata = 32'(s_reg.ien);
        ADDR_RTSL: s_next.prdata = 32'(s_reg.rtsl);
        ADDR_LINE: s_next.prdata = 32'({s_reg.cnt, s_reg.rts_n, CTS_N,
                                        s_reg.tbits != 4'h0, s_reg.thr_v});
        ADDR_TXD, ADDR_ICLR: s_next.prdata = 32'h0000_0000;
        default: begin
          s_next.prdata = 32'h0000_0000;
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (APB_REQ.paddr)
        ADDR_CTRL: s_next.ctrl = APB_REQ.pwdata[CTRL_W-1:0];
        ADDR_FMT: s_next.fmt = APB_REQ.pwdata[FMT_W-1:0];
        ADDR_DLL: s_next.dll = APB_REQ.pwdata[7:0];
        ADDR_DLH: s_next.dlh = APB_REQ.pwdata[7:0];
        ADDR_IEN: s_next.ien = APB_REQ.pwdata[ST_W-1:0];
        ADDR_RTSL: s_next.rtsl = APB_REQ.pwdata[2:0];
        ADDR_ICLR: s_next.stat = s_reg.stat & ~APB_REQ.pwdata[ST_W-1:0];
        ADDR_TXD: begin
          if (!s_reg.ctrl[C_DMA] && !s_reg.thr_v) begin
            s_next.thr = APB_REQ.pwdata[7:0];
            s_next.thr_v = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // transmit channel fills the holding stage
    if (s_reg.ctrl[C_DMA] && TX_DMA_ACK && !s_reg.thr_v) begin
      s_next.thr = TX_DMA_DATA;
      s_next.thr_v = 1'b1;
    end
    // transmitter
    if (tick) begin
      s_next.tsub = s_reg.tsub + 4'h1;
    end
    if (s_reg.tbits != 4'h0 && tbit_end) begin
      s_next.tsh = {1'b1, s_reg.tsh[11:1]};
      s_next.tbits = s_reg.tbits - 4'h1;
      s_next.tx_out = s_reg.tsh[1];
      if (s_reg.tbits == 4'h1) begin
        s_next.tx_out = 1'b1;
        if (s_reg.ctrl[C_TXSEL]) begin
          s_next.stat[S_TX] = 1'b1;
        end
      end
    end else if (tx_load) begin
      d = low_bits(s_reg.thr, wl);
      // start low, data lsb first, stops high
      s_next.tsh = (12'hfff << (wl + 4'h1)) | {3'b000, d, 1'b0};
      if (s_reg.fmt[F_PAR]) begin
        s_next.tsh[wl + 4'h1] = (^d) ^ !s_reg.fmt[F_EVEN];
      end
      s_next.tbits = flen;
      s_next.tsub = 4'h0;
      s_next.tx_out = 1'b0;
      s_next.thr_v = 1'b0;
      // holding stage free for the next word
      if (!s_reg.ctrl[C_TXSEL]) begin
        s_next.stat[S_TX] = 1'b1;
      end
    end
    // receiver
    case (s_reg.rst)
      RX_IDLE: begin
        s_next.rlow = 1'b0;
        // falling edge starts the bit count
        if (tick && !s_reg.rxd_d) begin
          s_next.rst = RX_BITS;
          s_next.rsub = 4'h1;
          s_next.rbits = 4'h0;
          s_next.rlow = 1'b1;
          // bypass has no centre tick: the edge tick is the start
          if (bypass) begin
            s_next.rbits = 4'h1;
            s_next.rsh = {1'b0, s_reg.rsh[10:1]};
          end
        end
      end
      RX_BITS: begin
        if (tick) begin
          s_next.rsub = s_reg.rsub + 4'h1;
          s_next.rlow = s_reg.rlow || !s_reg.rxd_d;
        end
        if (rsample) begin
          s_next.rlow = 1'b0;
          s_next.rbits = s_reg.rbits + 4'h1;
          s_next.rsh = {rbit, s_reg.rsh[10:1]};
          if (s_reg.rbits == 4'h0 && rbit) begin
            s_next.rst = RX_IDLE;
          end else if (s_reg.rbits == flen - 4'h1) begin
            s_next.rst = RX_IDLE;
            al = {rbit, s_reg.rsh[10:1]} >> (4'hc - flen);
            d = low_bits(al[7:0], wl);
            if (s_reg.fmt[F_PAR]
                && (al[wl] != ((^d) ^ !s_reg.fmt[F_EVEN]))) begin
              s_next.stat[S_PE] = 1'b1;
            end
            if (!al[wl + {3'b000, s_reg.fmt[F_PAR]}]) begin
              s_next.stat[S_FE] = 1'b1;
            end
            if (s_reg.cnt == FIFO_DEPTH) begin
              s_next.stat[S_OE] = 1'b1;
            end else begin
              push = 1'b1;
              s_next.fifo[s_reg.wp] = d;
              s_next.wp = s_reg.wp + 2'h1;
              s_next.stat[S_RX] = 1'b1;
            end
          end
        end
      end
      default: s_next.rst = RX_IDLE;
    endcase
    if (pop) begin
      s_next.rp = s_reg.rp + 2'h1;
    end
    s_next.cnt = s_reg.cnt + {2'b00, push} - {2'b00, pop};
    s_next.rts_n = HAS_FLOW && s_reg.ctrl[C_AFLOW]
                   && s_next.cnt > s_reg.rtsl;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.fmt <= FMT_RST;
      s_reg.dll <= DLL_RST;
      s_reg.dlh <= DLH_RST;
      s_reg.rtsl <= RTSL_RST;
      s_reg.tx_out <= 1'b1;
      s_reg.rxd_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign APB_RSP.prdata = s_reg.prdata;
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = s_reg.pslverr;
  // infrared sends a short low pulse per zero bit
  assign TXD = (sir && s_reg.tbits != 4'h0) ?
               !(!s_reg.tx_out && s_reg.tsub < SIR_PULSE) : s_reg.tx_out;
  assign RTS_N = s_reg.rts_n;
  // timer measures the line for baud detection
  assign RXD_TIMER = s_reg.rxd_d;
  assign TX_DMA_REQ = s_reg.ctrl[C_DMA] && !s_reg.thr_v;
  assign RX_DMA_REQ = s_reg.ctrl[C_DMA] && s_reg.cnt != 3'h0;
  assign RX_DMA_DATA = s_reg.fifo[s_reg.rp];
  // low priority unless software raises it
  assign DMA_PRIO_HIGH = s_reg.ctrl[C_PRIO];
  // each source gated by its enable
  assign IRQ = |(s_reg.stat & s_reg.ien);

  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence load_seq;
    tx_load && s_reg.tbits == 4'h0;
  endsequence

  a_frame_len: assert property (load_seq |->
    flen >= FRAME_MIN && flen <= FRAME_MAX)
    else $error("frame length out of range");
  a_start_low: assert property ((load_seq and !sir) |=> !TXD)
    else $error("no start bit after load");
  a_cts_hold: assert property ((s_reg.tbits == 4'h0 && HAS_FLOW
    && CTS_N) |=> s_reg.tbits == 4'h0)
    else $error("character started while clear-to-send high");
  a_rts_level: assert property ((HAS_FLOW && s_reg.ctrl[C_AFLOW]
    && s_reg.cnt > s_reg.rtsl && !pop && !push) |=> RTS_N)
    else $error("request-to-send held above high-water");
  a_irq_mask: assert property ((s_reg.ien == '0) |-> !IRQ)
    else $error("masked interrupt reached output");
  a_dma_tx_req: assert property ((s_reg.ctrl[C_DMA]
    && TX_DMA_REQ && TX_DMA_ACK) |=> s_reg.thr_v ##0 !TX_DMA_REQ)
    else $error("dma word not taken");
  a_hold_free: assert property (load_seq |=> !s_reg.thr_v
    && s_reg.tbits != 4'h0)
    else $error("holding stage not passed to shifter");
  a_tx_sel: assert property ((s_reg.ctrl[C_TXSEL]
    && s_reg.tbits == 4'h1 && tbit_end && !wr) |=> s_reg.stat[S_TX])
    else $error("end-of-shift interrupt missing");
  a_sir_idle: assert property ((s_reg.tbits == 4'h0) |-> TXD)
    else $error("line not idle high");
endmodule : uart_port
